// File: lcd_tv_digital_video_port_test.sv
// Self-checking testbench of the LCD/TV digital video port.
`timescale 1ns/10ps
module lcd_tv_digital_video_port_test;
  import video_port_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [11:0] pixel_in = 12'h000;
  logic tv_run = 1'b0;
  logic hot_plug = 1'b0;
  logic pull_data = 1'b0;
  logic [31:0] readdata;
  logic waitrequest, pixel_ready, irq, enc_pin, hs, vs, blank_n;
  logic [1:0] pclk;
  logic [11:0] pdata;
  logic sb_ci, sb_co, sb_coe_n, sb_di, sb_do, sb_doe_n;
  integer seed = 83403;
  int bad_count = 0;
  int check_count = 0;
  int steps, hs_n, vs_n, bl_n;
  logic [31:0] reg_q[$];
  logic [11:0] pix_q[$];
  logic watch = 1'b0;
  logic pixchk = 1'b0;
  logic hpol = 1'b1;
  logic vpol = 1'b1;
  logic single = 1'b0;
  logic fell;
  logic clk_prev = 1'b0;
  logic [14:0] out_prev = 15'h0000;
  wire [14:0] outs = {pdata, hs, vs, blank_n};

  always #20 clk = ~clk;
  always @(posedge clk) pixel_in <= 12'($random(seed));

  lcd_tv_video_port lcd_tv_video_port_inst (.clk(clk), .resetn(resetn), .ce(1'b1),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .pixel_in(pixel_in), .pixel_ready(pixel_ready), .irq(irq),
    .encoder_clock_or_panel_irq(enc_pin), .port_clock_out(pclk), .port_pixel_data(pdata),
    .port_horizontal_sync(hs), .port_vertical_sync(vs), .blank_border_n(blank_n),
    .sideband_clock_in(sb_ci), .sideband_clock_out(sb_co), .sideband_clock_oe_n(sb_coe_n),
    .sideband_data_in(sb_di), .sideband_data_out(sb_do), .sideband_data_oe_n(sb_doe_n));

  video_far_side video_far_side_inst (.tv_run(tv_run), .hot_plug(hot_plug),
    .pull_data(pull_data), .encoder_clock_or_panel_irq(enc_pin),
    .sideband_clock_oe_n(sb_coe_n), .sideband_data_oe_n(sb_doe_n),
    .sideband_clock_in(sb_ci), .sideband_data_in(sb_di));

  // ****************************************
  // Compare and bus tasks
  // ****************************************
  task check32(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task check1(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Request is held until the edge that samples waitrequest low.
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    @(posedge clk iff !waitrequest);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task rd(input logic [5:0] a, input logic [31:0] exp);
    reg_q.push_back(exp);
    bus(1'b0, a, 32'h00000000);
  endtask

  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Runs one whole frame of 10 x 5 pixel steps with counting switched on.
  task frame(input logic [31:0] ctrl);
    pixchk = ctrl[0] & ~ctrl[4];
    bus(1'b1, OFF_CTRL, ctrl);
    repeat (12) @(posedge clk);
    steps = 0;
    hs_n = 0;
    vs_n = 0;
    bl_n = 0;
    watch = 1'b1;
    wait (steps == 50);
    watch = 1'b0;
  endtask

  task test_done;
    if (bad_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Result watchers
  // ****************************************
  always @(posedge clk) begin
    if (read && !waitrequest) begin
      check32("readdata", reg_q.pop_front(), readdata);
    end
  end

  // Samples just after each edge so that the edge's updates have landed.
  always @(posedge clk) begin
    #1;
    fell = clk_prev & ~pclk[0];
    if (watch) begin
      check1("clock_pair", single ? 1'b0 : ~pclk[0], pclk[1]);
      if (outs !== out_prev) check1("change_on_fall", 1'b1, fell);
      if (fell) begin
        hs_n += (hs === hpol);
        vs_n += (vs === vpol);
        bl_n += (blank_n === 1'b0);
        steps++;
      end
    end
    if (pixchk && fell) check32("pixel", blank_n ? 32'h0 : pix_q.pop_front(), pdata);
    if (pixchk && pixel_ready) pix_q.push_back(pixel_in);
    clk_prev = pclk[0];
    out_prev = outs;
  end

  initial begin
    #(40 * 20000);
    bad_count++;
    test_done();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd(OFF_CTRL, 32'h00000000);
    rd(OFF_HTIME, 32'h00320280);
    rd(OFF_VSYNC, 32'h001EC1EA);
    bus(1'b1, 6'h3C, 32'hFFFFFFFF);
    rd(6'h3C, 32'h00000000);
    rd(OFF_STATUS, 32'h01000000);
    bus(1'b1, OFF_HTIME, 32'h0000A004);
    bus(1'b1, OFF_HSYNC, 32'h00008006);
    bus(1'b1, OFF_VTIME, 32'h00005002);
    bus(1'b1, OFF_VSYNC, 32'h00005004);
    bus(1'b1, OFF_BORDER, 32'h00000101);
    frame(32'h0000000D);
    check32("blank_count", 32'd8, 32'(bl_n));
    check32("hsync_count", 32'd10, 32'(hs_n));
    check32("vsync_count", 32'd10, 32'(vs_n));
    pixchk = 1'b0;
    bus(1'b1, OFF_CTRL, 32'h00000000);
    pix_q.delete();
    rd(OFF_IRQ_STATUS, 32'h00000002);
    hpol = 1'b0;
    vpol = 1'b0;
    single = 1'b1;
    frame(32'h00000031);
    check32("border_count", 32'd24, 32'(bl_n));
    check32("hsync_low_count", 32'd10, 32'(hs_n));
    check32("vsync_low_count", 32'd10, 32'(vs_n));
    single = 1'b0;
    bus(1'b1, OFF_CTRL, 32'h00000003);
    tv_run <= 1'b1;
    repeat (20) @(posedge clk);
    steps = 0;
    watch = 1'b1;
    repeat (320) @(posedge clk);
    watch = 1'b0;
    check1("tv_rate", 1'b1, steps >= 39 && steps <= 41);
    tv_run <= 1'b0;
    settle(10);
    bus(1'b1, OFF_CTRL, 32'h00000000);
    bus(1'b1, OFF_IRQ_STATUS, 32'h00000003);
    bus(1'b1, OFF_IRQ_MASK, 32'h00000001);
    rd(OFF_IRQ_STATUS, 32'h00000000);
    hot_plug <= 1'b1;
    settle(10);
    hot_plug <= 1'b0;
    settle(6);
    rd(OFF_IRQ_STATUS, 32'h00000001);
    settle(1);
    check1("irq_raised", 1'b1, irq);
    bus(1'b1, OFF_IRQ_MASK, 32'h00000000);
    settle(1);
    check1("irq_masked", 1'b0, irq);
    bus(1'b1, OFF_IRQ_MASK, 32'h00000001);
    bus(1'b1, OFF_IRQ_STATUS, 32'h00000001);
    rd(OFF_IRQ_STATUS, 32'h00000000);
    settle(1);
    check1("irq_cleared", 1'b0, irq);
    bus(1'b1, OFF_SIDEBAND, 32'h00000001);
    pull_data <= 1'b1;
    settle(6);
    check1("sb_clock_pull", 1'b0, sb_coe_n);
    check1("sb_clock_level", 1'b0, sb_co);
    check1("sb_data_free", 1'b1, sb_doe_n);
    rd(OFF_SIDEBAND, 32'h00000001);
    bus(1'b1, OFF_SIDEBAND, 32'h00000000);
    pull_data <= 1'b0;
    settle(6);
    check1("sb_clock_free", 1'b1, sb_coe_n);
    rd(OFF_SIDEBAND, 32'h00000300);
    bus(1'b1, OFF_SIDEBAND, 32'h00000003);
    bus(1'b1, OFF_CTRL, 32'h00000005);
    settle(1);
    check1("sb_data_pull", 1'b0, sb_doe_n);
    check1("sb_data_low", 1'b0, sb_do);
    settle(20);
    // Reset lands on a running port with both sideband lines pulled.
    @(posedge clk);
    resetn <= 1'b0;
    settle(3);
    check1("reset_hsync", 1'b1, hs);
    check1("reset_clock", 1'b0, |pclk);
    check1("reset_blank", 1'b1, blank_n);
    check1("reset_sb_clock", 1'b1, sb_coe_n);
    check1("reset_sb_data", 1'b1, sb_doe_n);
    check1("reset_wait", 1'b1, waitrequest);
    check32("reset_pixel", 32'h00000000, 32'(pdata));
    @(posedge clk);
    resetn <= 1'b1;
    rd(OFF_CTRL, 32'h00000000);
    rd(OFF_HTIME, 32'h00320280);
    settle(2);
    test_done();
  end
endmodule // lcd_tv_digital_video_port_test

// File: lcd_tv_video_port.sv
// Digital video port: timing generator, pin logic and Avalon-MM register slave.
//
// How it works
// RULE1 - In TV mode the encoder's clock on the shared pin times every pixel (20 to 40 MHz).
// RULE2 - In panel mode the shared pin is an active-low hot-plug interrupt, pulled high idle.
// RULE3 - The port clock goes out as a differential pair, at most 85 MHz.
// RULE4 - Below 65 MHz a single-ended mode drives only bit 0 and leaves bit 1 unused.
// RULE5 - In blank mode the blank output is asserted over active pixels only.
// RULE6 - In border mode the blank output is asserted over active and border pixels.
// RULE7 - Pixels leave on a twelve-bit data bus, bits 11 down to 0.
// RULE8 - Vertical sync is driven with a software-selected active level.
// RULE9 - Horizontal sync is driven with its own software-selected active level.
// RULE10 - A two-wire open-drain sideband only pulls its lines low or releases them.
// RULE11 - The display reference clock comes from an outside synthesizer.
// RULE12 - The active-low global reset clears all port logic while asserted.
// RULE13 - Pixel data, syncs and blank change only on edges of the forwarded port clock; the code sets them idle at once when enable is cleared.
`timescale 1ns/10ps
module lcd_tv_video_port (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Avalon-MM register slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Pixel source
  input wire logic [11:0] pixel_in,
  output logic pixel_ready,
  // Interrupt
  output logic irq,
  // Video pins
  input wire logic encoder_clock_or_panel_irq,
  output logic [1:0] port_clock_out,
  output logic [11:0] port_pixel_data,
  output logic port_horizontal_sync,
  output logic port_vertical_sync,
  output logic blank_border_n,
  // Open-drain sideband
  input wire logic sideband_clock_in,
  output logic sideband_clock_out,
  output logic sideband_clock_oe_n,
  input wire logic sideband_data_in,
  output logic sideband_data_out,
  output logic sideband_data_oe_n
);
  import video_port_pkg::*;

  state_type r;
  state_type n;
  logic tick;
  logic [1:0] hr_ahead;
  logic [1:0] vr_ahead;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Three-stage synchroniser; a level counts once stages two and three agree.
  function automatic sync3_type sync_step(sync3_type s, logic pin);
    sync3_type res;
    res.ff = {s.ff[1:0], pin};
    res.stable = (s.ff[1] == s.ff[2]) ? s.ff[2] : s.stable;
    return res;
  endfunction

  // Returns {inside active plus border, inside active}.
  function automatic logic [1:0] region(logic [11:0] cnt, logic [7:0] bord, logic [11:0] act);
    logic [12:0] c;
    logic [12:0] lo;
    logic [12:0] hi;
    logic [12:0] top;
    c = {1'h0, cnt};
    lo = {5'h00, bord};
    hi = 13'(lo + {1'h0, act});
    top = 13'(hi + lo);
    return {c < top, (c >= lo) && (c < hi)};
  endfunction

  function automatic logic in_window(logic [11:0] cnt, window_type w);
    return (cnt >= w.start) && (cnt < w.stop);
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [31:0] wm;
    logic [1:0] clr;
    logic [1:0] set;
    logic [1:0] hr;
    logic [1:0] vr;
    logic src;
    logic tv_next;
    wm = '0;
    clr = '0;
    set = '0;
    hr = '0;
    vr = '0;
    src = 1'h0;
    tv_next = 1'h0;
    n = r;
    tick = 1'h0;

    // Register slave: one wait cycle, writes take effect on the answer edge.
    case (r.bus)
      BUS_IDLE: begin
        if (read || write) begin
          n.bus = BUS_ANSWER;
          n.rdata = '0;
          if (read) begin
            case (address)
              OFF_CTRL: n.rdata = {26'h0, r.ctrl};
              OFF_HTIME: n.rdata = {8'h00, r.htime};
              OFF_HSYNC: n.rdata = {8'h00, r.hsync};
              OFF_VTIME: n.rdata = {8'h00, r.vtime};
              OFF_VSYNC: n.rdata = {8'h00, r.vsync};
              OFF_BORDER: n.rdata = {16'h0000, r.border};
              OFF_SIDEBAND: n.rdata = {22'h0, r.sbd.stable, r.sbc.stable, 6'h00, r.sb_drive};
              OFF_IRQ_STATUS: n.rdata = {30'h0, r.irq_status};
              OFF_IRQ_MASK: n.rdata = {30'h0, r.irq_mask};
              OFF_STATUS: n.rdata = {7'h00, r.link.stable, r.vcnt, r.hcnt};
              default: n.rdata = '0;
            endcase
          end
        end
      end
      BUS_ANSWER: begin
        n.bus = BUS_IDLE;
        if (write) begin
          case (address)
            OFF_CTRL: begin
              wm = merge({26'h0, r.ctrl}, writedata, byteenable);
              n.ctrl = wm[5:0];
            end
            OFF_HTIME: begin
              wm = merge({8'h00, r.htime}, writedata, byteenable);
              n.htime = wm[23:0];
            end
            OFF_HSYNC: begin
              wm = merge({8'h00, r.hsync}, writedata, byteenable);
              n.hsync = wm[23:0];
            end
            OFF_VTIME: begin
              wm = merge({8'h00, r.vtime}, writedata, byteenable);
              n.vtime = wm[23:0];
            end
            OFF_VSYNC: begin
              wm = merge({8'h00, r.vsync}, writedata, byteenable);
              n.vsync = wm[23:0];
            end
            OFF_BORDER: begin
              wm = merge({16'h0000, r.border}, writedata, byteenable);
              n.border = wm[15:0];
            end
            OFF_SIDEBAND: begin
              wm = merge({30'h0, r.sb_drive}, writedata, byteenable);
              n.sb_drive = wm[1:0];
            end
            OFF_IRQ_STATUS: begin
              wm = merge('0, writedata, byteenable);
              clr = wm[1:0];
            end
            OFF_IRQ_MASK: begin
              wm = merge({30'h0, r.irq_mask}, writedata, byteenable);
              n.irq_mask = wm[1:0];
            end
            default: n.bus = BUS_IDLE;
          endcase
        end
      end
      default: n.bus = BUS_IDLE;
    endcase

    // Outside pins pass the synchronisers before anything looks at them.
    n.link = sync_step(r.link, encoder_clock_or_panel_irq);
    n.sbc = sync_step(r.sbc, sideband_clock_in);
    n.sbd = sync_step(r.sbd, sideband_data_in);

    // RULE2 hot-plug event
    if (!r.ctrl.tv_mode && r.link.stable && !n.link.stable) begin
      set[IRQ_HOTPLUG_BIT] = 1'h1;
    end

    // RULE1 clock source select
    tv_next = n.ctrl.tv_mode;
    n.pclk = (n.ctrl.enable && !tv_next) ? ~r.pclk : 1'h0;
    src = tv_next ? n.link.stable : n.pclk;
    // RULE3 differential pair, RULE4 single-ended mode
    if (!n.ctrl.enable) begin
      n.clk_out = 2'h0;
    end else if (n.ctrl.single_ended) begin
      n.clk_out = {1'h0, src};
    end else begin
      n.clk_out = {~src, src};
    end

    // RULE13 update on falling port clock
    // Data moves on the falling edge so it is settled at the receiver's rising edge.
    tick = r.ctrl.enable && n.ctrl.enable && r.clk_out[0] && !src;

    if (!n.ctrl.enable) begin
      n.hcnt = '0;
      n.vcnt = '0;
      n.data = '0;
      n.hs = ~n.ctrl.hsync_high;
      n.vs = ~n.ctrl.vsync_high;
      n.blank_n = 1'h1;
    end else if (tick) begin
      if (r.hcnt >= 12'(r.htime.total - 12'h001)) begin
        n.hcnt = '0;
        n.vcnt = (r.vcnt >= 12'(r.vtime.total - 12'h001)) ? 12'h000 : 12'(r.vcnt + 12'h001);
      end else begin
        n.hcnt = 12'(r.hcnt + 12'h001);
      end
      hr = region(n.hcnt, n.border.horiz, n.htime.active);
      vr = region(n.vcnt, n.border.vert, n.vtime.active);
      // RULE7 pixel bus
      n.data = (hr[0] && vr[0]) ? pixel_in : 12'h000;
      // RULE9 horizontal sync polarity
      n.hs = in_window(n.hcnt, n.hsync) ? n.ctrl.hsync_high : ~n.ctrl.hsync_high;
      // RULE8 vertical sync polarity
      n.vs = in_window(n.vcnt, n.vsync) ? n.ctrl.vsync_high : ~n.ctrl.vsync_high;
      // RULE5 RULE6 blank or border span
      n.blank_n = n.ctrl.border_mode ? ~(hr[1] && vr[1]) : ~(hr[0] && vr[0]);
      if (n.hcnt == 12'h000 && n.vcnt == 12'h000) begin
        set[IRQ_FRAME_BIT] = 1'h1;
      end
    end

    // A new event wins over a clear written in the same cycle.
    n.irq_status = (r.irq_status & ~clr) | set;
  end

  // ****************************************
  // State register
  // ****************************************
  // RULE12 global reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= STATE_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign waitrequest = !(ce && r.bus == BUS_ANSWER);
  assign readdata = r.rdata;
  // The position after this step decides whether pixel_in is consumed.
  assign hr_ahead = region(n.hcnt, n.border.horiz, n.htime.active);
  assign vr_ahead = region(n.vcnt, n.border.vert, n.vtime.active);
  assign pixel_ready = ce && tick && (n.data == pixel_in) && hr_ahead[0] && vr_ahead[0];
  assign irq = |(r.irq_status & r.irq_mask);
  assign port_clock_out = r.clk_out;
  assign port_pixel_data = r.data;
  assign port_horizontal_sync = r.hs;
  assign port_vertical_sync = r.vs;
  assign blank_border_n = r.blank_n;
  // RULE10 open-drain sideband
  assign sideband_clock_out = 1'h0;
  assign sideband_data_out = 1'h0;
  assign sideband_clock_oe_n = ~r.sb_drive[0];
  assign sideband_data_oe_n = ~r.sb_drive[1];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic [1:0] hr_now;
  logic [1:0] vr_now;
  assign hr_now = region(r.hcnt, r.border.horiz, r.htime.active);
  assign vr_now = region(r.vcnt, r.border.vert, r.vtime.active);

  sequence s_link_fall;
    $fell(r.link.stable);
  endsequence

  sequence s_pixel_step;
    ce && tick ##1 r.ctrl.enable;
  endsequence

  a_tv_clock_follow: assert property ( // RULE1
    (r.ctrl.enable && r.ctrl.tv_mode && $past(r.ctrl.tv_mode)) and s_link_fall |->
      $fell(port_clock_out[0]))
    else $error("port clock did not follow the encoder clock");

  a_hot_plug_flag: assert property ( // RULE2
    (!$past(r.ctrl.tv_mode)) and s_link_fall |-> r.irq_status[IRQ_HOTPLUG_BIT])
    else $error("hot plug edge not flagged");

  a_diff_pair: assert property ( // RULE3
    r.ctrl.enable && !r.ctrl.single_ended && $stable(r.ctrl) |->
      port_clock_out[1] == ~port_clock_out[0])
    else $error("port clock pair not complementary");

  a_single_ended: assert property ( // RULE4
    r.ctrl.single_ended |-> !port_clock_out[1])
    else $error("clock bit one driven in single-ended mode");

  a_blank_active: assert property ( // RULE5
    s_pixel_step ##0 !r.ctrl.border_mode |-> blank_border_n == !(hr_now[0] && vr_now[0]))
    else $error("blank indication outside active pixels");

  a_border_span: assert property ( // RULE6
    s_pixel_step ##0 r.ctrl.border_mode |-> blank_border_n == !(hr_now[1] && vr_now[1]))
    else $error("border indication span wrong");

  a_data_idle: assert property ( // RULE7
    port_pixel_data != 12'h000 |-> hr_now[0] && vr_now[0])
    else $error("pixel data outside active area");

  a_vsync_level: assert property ( // RULE8
    s_pixel_step |-> port_vertical_sync ==
      (in_window(r.vcnt, r.vsync) ? r.ctrl.vsync_high : ~r.ctrl.vsync_high))
    else $error("vertical sync level wrong");

  a_hsync_level: assert property ( // RULE9
    s_pixel_step |-> port_horizontal_sync ==
      (in_window(r.hcnt, r.hsync) ? r.ctrl.hsync_high : ~r.ctrl.hsync_high))
    else $error("horizontal sync level wrong");

  a_sideband_pull: assert property ( // RULE10
    r.sb_drive[0] |-> !sideband_clock_oe_n && !sideband_clock_out)
    else $error("sideband clock not pulled low");

  a_pixel_on_edge: assert property ( // RULE13
    r.ctrl.enable && $past(r.ctrl.enable) && $changed(port_pixel_data) |->
      $fell(port_clock_out[0]))
    else $error("pixel data changed off a port clock edge");

endmodule // lcd_tv_video_port

// File: video_far_side.sv
// Behavioural encoder or panel standing at the far side of the video port.
`timescale 1ns/10ps
module video_far_side (
  // Commands from the bench
  input wire logic tv_run,
  input wire logic hot_plug,
  input wire logic pull_data,
  // Port pins
  output logic encoder_clock_or_panel_irq,
  input wire logic sideband_clock_oe_n,
  input wire logic sideband_data_oe_n,
  output logic sideband_clock_in,
  output logic sideband_data_in
);
  logic enc_clk = 1'b0;
  always begin
    #160;
    if (tv_run) begin
      enc_clk = ~enc_clk;
    end
  end
  assign encoder_clock_or_panel_irq = tv_run ? enc_clk : ~hot_plug;
  assign sideband_clock_in = sideband_clock_oe_n;
  assign sideband_data_in = sideband_data_oe_n & ~pull_data;
endmodule // video_far_side

// File: video_port_pkg.sv
// Constants, register map and carrier types of the LCD/TV digital video port.
package video_port_pkg;

  // ****************************************
  // Clock rates
  // ****************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int DISPLAY_REF_HZ = 48_000_000;
  localparam int ENC_CLK_MIN_HZ = 20_000_000;
  localparam int ENC_CLK_MAX_HZ = 40_000_000;
  localparam int PORT_CLK_MAX_HZ = 85_000_000;
  localparam int SINGLE_END_MAX_HZ = 65_000_000;
  // Panel-mode port clock toggles every cycle: CLK_HZ / 2.
  localparam int LCD_PORT_CLK_HZ = CLK_HZ / 2;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_HTIME = 6'h04;
  localparam logic [5:0] OFF_HSYNC = 6'h08;
  localparam logic [5:0] OFF_VTIME = 6'h0C;
  localparam logic [5:0] OFF_VSYNC = 6'h10;
  localparam logic [5:0] OFF_BORDER = 6'h14;
  localparam logic [5:0] OFF_SIDEBAND = 6'h18;
  localparam logic [5:0] OFF_IRQ_STATUS = 6'h1C;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h20;
  localparam logic [5:0] OFF_STATUS = 6'h24;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SB_PIN_POS = 8;
  localparam int STAT_VCNT_POS = 12;
  localparam int STAT_LINK_POS = 24;
  localparam int IRQ_HOTPLUG_BIT = 0;
  localparam int IRQ_FRAME_BIT = 1;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_ANSWER = 2'h1
  } bus_state_type;

  typedef struct packed {
    logic single_ended;
    logic border_mode;
    logic vsync_high;
    logic hsync_high;
    logic tv_mode;
    logic enable;
  } ctrl_type;

  typedef struct packed {
    logic [11:0] total;
    logic [11:0] active;
  } span_type;

  typedef struct packed {
    logic [11:0] stop;
    logic [11:0] start;
  } window_type;

  typedef struct packed {
    logic [7:0] vert;
    logic [7:0] horiz;
  } border_type;

  typedef struct packed {
    logic [2:0] ff;
    logic stable;
  } sync3_type;

  typedef struct packed {
    bus_state_type bus;
    logic [31:0] rdata;
    ctrl_type ctrl;
    span_type htime;
    window_type hsync;
    span_type vtime;
    window_type vsync;
    border_type border;
    logic [1:0] sb_drive;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    sync3_type link;
    sync3_type sbc;
    sync3_type sbd;
    logic pclk;
    logic [1:0] clk_out;
    logic [11:0] hcnt;
    logic [11:0] vcnt;
    logic [11:0] data;
    logic hs;
    logic vs;
    logic blank_n;
  } state_type;

  // ****************************************
  // Reset values
  // ****************************************
  localparam ctrl_type CTRL_RST = 6'h00;
  localparam span_type HTIME_RST = 24'h320280;
  localparam window_type HSYNC_RST = 24'h2F0290;
  localparam span_type VTIME_RST = 24'h20D1E0;
  localparam window_type VSYNC_RST = 24'h1EC1EA;
  localparam border_type BORDER_RST = 16'h0000;
  localparam sync3_type SYNC_RST = 4'hF;
  localparam state_type STATE_RST = '{
    bus: BUS_IDLE, ctrl: CTRL_RST, htime: HTIME_RST, hsync: HSYNC_RST,
    vtime: VTIME_RST, vsync: VSYNC_RST, border: BORDER_RST,
    link: SYNC_RST, sbc: SYNC_RST, sbd: SYNC_RST,
    hs: 1'h1, vs: 1'h1, blank_n: 1'h1, default: '0
  };

endpackage // video_port_pkg
